// file: logic/hirq_pkg.sv
/*
  Package for the serial channel event and interrupt status block.
  Register offsets, field positions, reset values and widths.
  Assumes an AHB-Lite slave with 32-bit data, one word per register.
*/
package hirq_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HIRQ_OFF_PRIMARY  = 8'h00;
  localparam logic [7:0] HIRQ_OFF_EXTENDED = 8'h04;
  localparam logic [7:0] HIRQ_OFF_MASK     = 8'h08;
  localparam logic [7:0] HIRQ_OFF_CONFIG   = 8'h0C;
  localparam logic [7:0] HIRQ_OFF_CTRLFLD  = 8'h10;
  localparam logic [7:0] HIRQ_OFF_FIRSTADR = 8'h14;
  localparam logic [7:0] HIRQ_OFF_RXSTAT   = 8'h18;
  localparam logic [7:0] HIRQ_OFF_TXCOUNT  = 8'h1C;
  localparam logic [7:0] HIRQ_OFF_COMMAND  = 8'h20;

  // ----------------------------------------------------------------
  // Primary status bit positions (also mask bits)
  // ----------------------------------------------------------------
  localparam int HIRQ_P_RME = 7;
  localparam int HIRQ_P_RPF = 6;
  localparam int HIRQ_P_XPR = 4;

  // ----------------------------------------------------------------
  // Extended status bit positions
  // ----------------------------------------------------------------
  localparam int HIRQ_E_XMR = 7;
  localparam int HIRQ_E_XDU = 6;
  localparam int HIRQ_E_RFO = 4;
  localparam int HIRQ_E_RFS = 3;

  // ----------------------------------------------------------------
  // Configuration bits
  // ----------------------------------------------------------------
  localparam int HIRQ_C_DMA   = 0;
  localparam int HIRQ_C_AUTO  = 1;
  localparam int HIRQ_C_BUS   = 2;
  localparam int HIRQ_C_RFSEN = 3;

  // ----------------------------------------------------------------
  // Command bits (write-only, one-cycle pulses)
  // ----------------------------------------------------------------
  localparam int HIRQ_K_TX_RESET_CMD = 0;
  localparam int HIRQ_K_XTF  = 1;
  localparam int HIRQ_K_XIF  = 2;
  localparam int HIRQ_K_XME  = 3;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int         HIRQ_POOL_BYTES = 32;
  localparam int         HIRQ_RFS_DELAY  = 2;
  localparam logic [7:0] HIRQ_MASK_RST   = 8'h00;
  localparam logic [7:0] HIRQ_CFG_RST    = 8'h00;
  localparam logic [2:0] HIRQ_AH_WORD    = 3'h2;
  localparam logic [1:0] HIRQ_HT_NONSEQ  = 2'h2;

endpackage

// file: logic/hirq_sticky.sv
/*
  Sticky status byte with read-to-clear.
  Assumes set pulses from same-clock logic; a set in the clear cycle wins.
*/
module hirq_sticky #(
  parameter int WIDTH = 8
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic             clear,
  output logic      [WIDTH-1:0] status
);

  // ----------------------------------------------------------------
  // One flop per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Set beats clear so an event in the read cycle survives
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          status[i] <= 1'b0;
        end else if (set[i]) begin
          status[i] <= 1'b1;
        end else if (clear) begin
          status[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// file: logic/hirq_delay.sv
/*
  Event delay line counted in received-byte strobes.
  Assumes byte strobes and the start pulse come from the same clock.
*/
module hirq_delay #(
  parameter int BYTES = 2
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic start,
  input  wire logic byte_stb,
  output logic      done
);

  // ----------------------------------------------------------------
  // Byte counter
  // ----------------------------------------------------------------
  logic       busy;
  logic [3:0] cnt;

  // A new start restarts the wait; only one pending event is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt  <= 4'h0;
      end else if (busy && byte_stb) begin
        if (cnt == 4'(BYTES - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end

endmodule

// file: logic/hirq_top.sv
/*
  Receive and transmit event logic of one serial channel, with status,
  mask and configuration registers on an AHB-Lite slave.
  Assumes the FIFO, serial and protocol logic drive one-cycle event
  strobes on hclk and that the CPU reads status to clear it.
*/
// Added by the designer: the register offsets and register access over AHB-Lite.

module hirq_top
  import hirq_pkg::*;
#(
  parameter int POOL_BYTES = hirq_pkg::HIRQ_POOL_BYTES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_byte_stored,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_fifo_full,
  input  wire logic        rx_frame_begin,
  input  wire logic        rx_addr_match,
  input  wire logic        rx_open_flag,
  input  wire logic        rx_transparent0,
  input  wire logic        rx_byte_stb,
  input  wire logic [7:0]  rx_ctrl_in,
  input  wire logic [7:0]  rx_addr_in,
  input  wire logic [3:0]  rx_stat_in,
  input  wire logic        dma_rx_msg_read,
  input  wire logic        tx_half_empty,
  input  wire logic        tx_frame_done,
  input  wire logic        tx_pos_ack,
  input  wire logic        tx_neg_ack,
  input  wire logic        tx_collision,
  input  wire logic        cts_in,
  input  wire logic        tx_byte_sent,
  input  wire logic        tx_shift_empty,
  output logic             irq_n,
  output logic             dma_mode,
  output logic [3:0]       tx_cmd
);

  // ----------------------------------------------------------------
  // Bus decode and register state
  // ----------------------------------------------------------------
  logic        ap_valid;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic [7:0]  mask_reg;
  logic [7:0]  cfg;
  logic [15:0] tx_count;
  logic [7:0]  rx_control_field;
  logic [7:0]  rx_first_address;
  logic [3:0]  rx_frame_status;
  logic [7:0]  primary_irq_status;
  logic [7:0]  extended_irq_status;
  logic [7:0]  set_primary;
  logic [7:0]  set_extended;
  logic        clr_primary;
  logic        clr_extended;
  logic        auto_mode;
  logic        bus_cfg;

  assign ap_valid  = hsel && hready && htrans == HIRQ_HT_NONSEQ;
  assign auto_mode = cfg[HIRQ_C_AUTO];
  assign bus_cfg   = cfg[HIRQ_C_BUS];

  // Capture address phase; slave is zero wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= ap_valid && hwrite;
      dp_addr <= haddr;
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data registered in the address phase, stands in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      unique case (haddr)
        HIRQ_OFF_PRIMARY:  hrdata <= {24'h0, primary_irq_status};
        HIRQ_OFF_EXTENDED: hrdata <= {24'h0, extended_irq_status};
        HIRQ_OFF_MASK:     hrdata <= {24'h0, mask_reg};
        HIRQ_OFF_CONFIG:   hrdata <= {24'h0, cfg};
        HIRQ_OFF_CTRLFLD:  hrdata <= {24'h0, rx_control_field};
        HIRQ_OFF_FIRSTADR: hrdata <= {24'h0, rx_first_address};
        HIRQ_OFF_RXSTAT:   hrdata <= {28'h0, rx_frame_status};
        HIRQ_OFF_TXCOUNT:  hrdata <= {16'h0, tx_count};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Clear at the edge that snapshots hrdata: a set landing in that same
  // cycle wins and stays pending, so no event vanishes unread
  assign clr_primary  = ap_valid && !hwrite
                        && haddr == HIRQ_OFF_PRIMARY;
  assign clr_extended = ap_valid && !hwrite
                        && haddr == HIRQ_OFF_EXTENDED;

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  // Reset leaves interrupt mode and all events unmasked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_reg <= HIRQ_MASK_RST;
      cfg      <= HIRQ_CFG_RST;
      tx_count <= 16'h0000;
    end else if (dp_wr) begin
      if (dp_addr == HIRQ_OFF_MASK) mask_reg <= hwdata[7:0];
      if (dp_addr == HIRQ_OFF_CONFIG) cfg <= hwdata[7:0];
      if (dp_addr == HIRQ_OFF_TXCOUNT) tx_count <= hwdata[15:0];
    end
  end

  // Commands are pulses; nothing is stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_cmd <= 4'h0;
    end else if (dp_wr && dp_addr == HIRQ_OFF_COMMAND) begin
      tx_cmd <= hwdata[3:0];
    end else begin
      tx_cmd <= 4'h0;
    end
  end

  // Mode bit exported to the FIFO logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_mode <= 1'b0;
    end else begin
      dma_mode <= cfg[HIRQ_C_DMA];
    end
  end

  // ----------------------------------------------------------------
  // Receive events
  // ----------------------------------------------------------------
  logic [5:0] rx_cnt;
  logic       rfs_start;
  logic       rfs_done;
  logic       rfs_ok;

  // Bytes of the current message since the last pool boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt <= 6'h00;
    end else if (rx_frame_end || rx_frame_begin) begin
      rx_cnt <= 6'h00;
    end else if (rx_byte_stored) begin
      if (rx_cnt == 6'(POOL_BYTES - 1)) begin
        rx_cnt <= 6'h00;
      end else begin
        rx_cnt <= rx_cnt + 6'h01;
      end
    end
  end

  // Address match, or opening flag in transparent mode 0
  assign rfs_start = rx_transparent0 ? rx_open_flag : rx_addr_match;

  hirq_delay #(
    .BYTES(HIRQ_RFS_DELAY)
  ) u_rfs_delay (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (rfs_start),
    .byte_stb (rx_byte_stb),
    .done     (rfs_done)
  );

  assign rfs_ok = rfs_done && cfg[HIRQ_C_RFSEN];

  // Frame info snapshots are loaded when the start delay ends, even with the RFS event disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_control_field <= 8'h00;
      rx_first_address <= 8'h00;
      rx_frame_status  <= 4'h0;
    end else if (rfs_done) begin
      rx_control_field <= rx_ctrl_in;
      rx_first_address <= rx_addr_in;
      rx_frame_status  <= rx_stat_in;
    end
  end

  // ----------------------------------------------------------------
  // Transmit events
  // ----------------------------------------------------------------
  logic        tx_active;
  logic        tx_transp;
  logic        eom_seen;
  logic [15:0] tx_sent;
  logic [7:0]  tx_over32;
  logic        eom_dma;
  logic        cts_s1;
  logic        cts_s2;
  logic        cts_d;
  logic        cts_fall;

  // Clear-to-send is a pin: two flops before any use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts_s1 <= 1'b0;
      cts_s2 <= 1'b0;
      cts_d  <= 1'b0;
    end else begin
      cts_s1 <= cts_in;
      cts_s2 <= cts_s1;
      cts_d  <= cts_s2;
    end
  end

  assign cts_fall = cts_d && !cts_s2;

  // Frame in progress, its kind, and the end-of-message state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_active <= 1'b0;
      tx_transp <= 1'b0;
      eom_seen  <= 1'b0;
      tx_sent   <= 16'h0000;
      tx_over32 <= 8'h00;
    end else if (tx_cmd[HIRQ_K_TX_RESET_CMD] || tx_frame_done) begin
      tx_active <= 1'b0;
      eom_seen  <= 1'b0;
      tx_sent   <= 16'h0000;
      tx_over32 <= 8'h00;
    end else begin
      if (tx_cmd[HIRQ_K_XTF] || tx_cmd[HIRQ_K_XIF]) begin
        tx_active <= 1'b1;
        tx_transp <= tx_cmd[HIRQ_K_XTF];
      end
      if ((!dma_mode && tx_cmd[HIRQ_K_XME]) || eom_dma)
        eom_seen <= 1'b1;
      if (tx_byte_sent) begin
        tx_sent <= tx_sent + 16'h0001;
        if (tx_sent == 16'(POOL_BYTES - 1)) tx_over32 <= 8'h01;
      end
    end
  end

  // DMA mode end of message: programmed count reached
  assign eom_dma = dma_mode && tx_active && tx_count != 16'h0000
                   && tx_sent == tx_count;

  // ----------------------------------------------------------------
  // Event set vectors and sticky status
  // ----------------------------------------------------------------
  always_comb begin
    set_primary  = 8'h00;
    set_extended = 8'h00;
    set_primary[HIRQ_P_RPF] = !dma_mode && rx_byte_stored && !rx_frame_end
                              && rx_cnt == 6'(POOL_BYTES - 1);
    set_primary[HIRQ_P_RME] = dma_mode ? dma_rx_msg_read
                                       : rx_frame_end;
    set_primary[HIRQ_P_XPR] =
        tx_cmd[HIRQ_K_TX_RESET_CMD]
      || (tx_half_empty && tx_active && !eom_seen && !dma_mode)
      || (tx_frame_done && tx_transp && eom_seen)
      || (auto_mode && tx_pos_ack);
    set_extended[HIRQ_E_RFO] = rx_fifo_full && rx_frame_begin;
    set_extended[HIRQ_E_RFS] = rfs_ok;
    set_extended[HIRQ_E_XMR] =
        (auto_mode && tx_neg_ack)
      || (bus_cfg && tx_collision && tx_over32[0])
      || (!bus_cfg && cts_fall && tx_over32[0] && tx_active);
    set_extended[HIRQ_E_XDU] = tx_active && tx_shift_empty
                               && !tx_half_empty && !eom_seen
                               && tx_sent != 16'h0000;
  end

  hirq_sticky #(
    .WIDTH(8)
  ) u_primary (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (set_primary),
    .clear   (clr_primary),
    .status  (primary_irq_status)
  );

  hirq_sticky #(
    .WIDTH(8)
  ) u_extended (
    .hclk    (hclk),
    .hresetn (hresetn),
    .set     (set_extended),
    .clear   (clr_extended),
    .status  (extended_irq_status)
  );

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Masking hides primary bits only; extended bits always request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(|(primary_irq_status & ~mask_reg)
                 || |extended_irq_status);
    end
  end

endmodule

// file: verif/hirq_chk.sv
/*
  Port checker for hirq_top, bound to every instance.
  Assumes hready is fed from hreadyout, so there are no wait states.
*/
module hirq_chk
  import hirq_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        rx_frame_end,
  input wire logic        rx_frame_begin,
  input wire logic        rx_fifo_full,
  input wire logic        irq_n,
  input wire logic        dma_mode,
  input wire logic [3:0]  tx_cmd
);
  logic       dp;
  logic       wr_q;
  logic [7:0] a_q;
  logic [7:0] msk;
  wire        wr_dp = dp && wr_q;

  // ------------------------------------------------------------
  // Bus shadow
  // ------------------------------------------------------------
  // Data phase follows every taken address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp   <= 1'h0;
      wr_q <= 1'h0;
      a_q  <= 8'h00;
    end else begin
      dp   <= hsel && hready && htrans == HIRQ_HT_NONSEQ;
      wr_q <= hwrite;
      a_q  <= haddr;
    end
  end

  // Mask copy, so masked sources are not expected to interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msk <= HIRQ_MASK_RST;
    end else if (wr_dp && a_q == HIRQ_OFF_MASK) begin
      msk <= hwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_cmd_pulse: assert property (
    wr_dp && a_q == HIRQ_OFF_COMMAND |=> tx_cmd == $past(hwdata[3:0]))
    else $error("command strobe differs from written bits");
  a_cmd_once: assert property (
    tx_cmd != 4'h0 |=> tx_cmd == 4'h0)
    else $error("command strobe longer than one cycle");
  a_reset_mode: assert property (
    $rose(hresetn) |-> !dma_mode && irq_n && tx_cmd == 4'h0)
    else $error("not idle in interrupt mode after reset");
  a_dma_select: assert property (
    wr_dp && a_q == HIRQ_OFF_CONFIG
    |=> ##1 dma_mode == $past(hwdata[HIRQ_C_DMA], 2))
    else $error("dma mode does not follow its config bit");
  a_irq_hold: assert property (
    !irq_n && !dp && !$past(dp) |=> !irq_n)
    else $error("interrupt released without a register access");
  a_rme_irq: assert property (
    rx_frame_end && !dma_mode && !msk[HIRQ_P_RME] |-> ##[1:3] !irq_n)
    else $error("message end did not interrupt");
  a_ovf_irq: assert property (
    rx_frame_begin && rx_fifo_full |-> ##[1:3] !irq_n)
    else $error("frame overflow did not interrupt");
  a_tx_reset_cmd_irq: assert property (
    tx_cmd[HIRQ_K_TX_RESET_CMD] && !msk[HIRQ_P_XPR] |-> ##[1:3] !irq_n)
    else $error("transmit reset did not report pool ready");
endmodule

bind hirq_top hirq_chk chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .rx_frame_end, .rx_frame_begin, .rx_fifo_full, .irq_n, .dma_mode, .tx_cmd
);

// file: verif/hirq_host.sv
/*
  Host CPU model: AHB-Lite master doing single word transfers.
  Assumes the one slave's hreadyout is the bus hready.
*/
module hirq_host
  import hirq_pkg::*;
(
  input  wire logic        hclk,
  output logic             hsel,
  output logic [7:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout
);
  // Idle bus at time zero
  initial begin
    hsel   = 1'h0;
    haddr  = 8'h00;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = HIRQ_AH_WORD;
    hwdata = 32'h0;
  end

  // Address phase held until ready, then data phase until ready;
  // released address and write data are inverted so no stale value looks valid
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= HIRQ_HT_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    haddr  <= ~a;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule

// file: verif/hirq_top_test.sv
/*
  Self-checking bench for hirq_top with random and directed events.
  Assumes the host model owns the bus, the bench the event strobes.
*/
`define chk(got, exp) \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end

module hirq_top_test import hirq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int e_bst = 0, e_end = 1, e_beg = 2, e_amt = 3, e_opf = 4,
    e_stb = 5, e_dmr = 6, e_tfd = 7, e_pak = 8, e_nak = 9, e_col = 10,
    e_bys = 11;

  logic        hclk    = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel, hwrite, hreadyout, hresp, irq_n, dma_mode;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [31:0] rnd = 32'h0;
  logic [3:0]  tx_cmd;
  logic [11:0] ev = 12'h000;
  logic        full = 1'h0, tr0 = 1'h0, half = 1'h0, cts = 1'h1;
  logic        shmt = 1'h0;
  int          bad_count = 0, cmp_count = 0, cycles = 0, seed = 74838;

  always #4 hclk = ~hclk;

  hirq_host host (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hrdata, .hreadyout);

  hirq_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .rx_byte_stored(ev[e_bst]), .rx_frame_end(ev[e_end]),
    .rx_fifo_full(full), .rx_frame_begin(ev[e_beg]),
    .rx_addr_match(ev[e_amt]), .rx_open_flag(ev[e_opf]),
    .rx_transparent0(tr0), .rx_byte_stb(ev[e_stb]),
    .rx_ctrl_in(rnd[7:0]), .rx_addr_in(rnd[15:8]),
    .rx_stat_in(rnd[19:16]), .dma_rx_msg_read(ev[e_dmr]),
    .tx_half_empty(half), .tx_frame_done(ev[e_tfd]),
    .tx_pos_ack(ev[e_pak]), .tx_neg_ack(ev[e_nak]),
    .tx_collision(ev[e_col]), .cts_in(cts), .tx_byte_sent(ev[e_bys]),
    .tx_shift_empty(shmt), .irq_n, .dma_mode, .tx_cmd);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] ex(input int b);
    ex = 32'h1 << b;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'h0, a, 32'h0, rd);
    `chk(rd, e)
  endtask

  // n one-cycle strobes, then time for status and interrupt to land
  task automatic pulse(input int i, input int n = 1);
    repeat (n) begin
      @(posedge hclk);
      ev[i] <= 1'h1;
      @(posedge hclk);
      ev[i] <= 1'h0;
    end
    repeat (3) @(posedge hclk);
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize;
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    for (int a = 0; a <= 12; a += 4) rdchk(8'(a), 32'h0);
    rdchk(8'h24, 32'h0);
    `chk(dma_mode, 1'h0)
    `chk(hresp, 1'h0)
    rnd <= $random(seed);
    @(posedge hclk);
    wr(HIRQ_OFF_MASK, rnd & 32'hD0);
    rdchk(HIRQ_OFF_MASK, rnd & 32'hD0);
    wr(HIRQ_OFF_MASK, 32'h0);
    // Pool full exactly at the 32nd byte, then message end
    pulse(e_bst, 31);
    rdchk(HIRQ_OFF_PRIMARY, 32'h0);
    pulse(e_bst);
    `chk(irq_n, 1'h0)
    rdchk(HIRQ_OFF_PRIMARY, ex(HIRQ_P_RPF));
    repeat (2) @(posedge hclk);
    `chk(irq_n, 1'h1)
    rdchk(HIRQ_OFF_PRIMARY, 32'h0);
    pulse(e_end);
    rdchk(HIRQ_OFF_PRIMARY, ex(HIRQ_P_RME));
    // Masked message end must not interrupt
    wr(HIRQ_OFF_MASK, ex(HIRQ_P_RME));
    pulse(e_end);
    `chk(irq_n, 1'h1)
    host.xfer(1'h0, HIRQ_OFF_PRIMARY, 32'h0, rd);
    wr(HIRQ_OFF_MASK, 32'h0);
    // DMA mode defers message end until the message is read out
    wr(HIRQ_OFF_CONFIG, ex(HIRQ_C_DMA));
    repeat (2) @(posedge hclk);
    `chk(dma_mode, 1'h1)
    pulse(e_end);
    rdchk(HIRQ_OFF_PRIMARY, 32'h0);
    pulse(e_dmr);
    rdchk(HIRQ_OFF_PRIMARY, ex(HIRQ_P_RME));
    wr(HIRQ_OFF_CONFIG, 32'h0);
    // Random fill level against frame starts
    repeat (6) begin
      rnd <= $random(seed);
      @(posedge hclk);
      full <= rnd[0];
      pulse(e_beg);
      full <= 1'h0;
      rdchk(HIRQ_OFF_EXTENDED, rnd[0] ? ex(HIRQ_E_RFO) : 32'h0);
    end
    // Frame start: disabled, address match, transparent opening flag
    for (int m = 0; m < 3; m++) begin
      rnd <= $random(seed);
      tr0 <= (m == 2);
      wr(HIRQ_OFF_CONFIG, (m > 0) ? ex(HIRQ_C_RFSEN) : 32'h0);
      pulse((m == 2) ? e_opf : e_amt);
      pulse(e_stb);
      rdchk(HIRQ_OFF_EXTENDED, 32'h0);
      pulse(e_stb);
      rdchk(HIRQ_OFF_EXTENDED, (m > 0) ? ex(HIRQ_E_RFS) : 32'h0);
      if (m > 0) begin
        rdchk(HIRQ_OFF_CTRLFLD, {24'h0, rnd[7:0]});
        rdchk(HIRQ_OFF_FIRSTADR, {24'h0, rnd[15:8]});
        rdchk(HIRQ_OFF_RXSTAT, {28'h0, rnd[19:16]});
      end
    end
    tr0 <= 1'h0;
    // Pool ready after reset command, repeatedly until message end
    half <= 1'h1;
    wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_TX_RESET_CMD));
    repeat (3) @(posedge hclk);
    rdchk(HIRQ_OFF_PRIMARY, ex(HIRQ_P_XPR));
    wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_XTF));
    repeat (2) begin
      repeat (3) @(posedge hclk);
      rdchk(HIRQ_OFF_PRIMARY, ex(HIRQ_P_XPR));
    end
    half <= 1'h0;
    wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_XME));
    host.xfer(1'h0, HIRQ_OFF_PRIMARY, 32'h0, rd);
    rdchk(HIRQ_OFF_PRIMARY, 32'h0);
    pulse(e_tfd);
    rdchk(HIRQ_OFF_PRIMARY, ex(HIRQ_P_XPR));
    // Auto mode acknowledges
    wr(HIRQ_OFF_CONFIG, ex(HIRQ_C_AUTO));
    wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_XIF));
    pulse(e_pak);
    rdchk(HIRQ_OFF_PRIMARY, ex(HIRQ_P_XPR));
    pulse(e_nak);
    rdchk(HIRQ_OFF_EXTENDED, ex(HIRQ_E_XMR));
    // Repeat after 32 bytes: point-to-point, then bus configuration
    for (int b = 0; b < 2; b++) begin
      wr(HIRQ_OFF_CONFIG, b ? ex(HIRQ_C_BUS) : 32'h0);
      wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_TX_RESET_CMD));
      wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_XTF));
      pulse(b ? e_col : e_nak);
      pulse(e_bys, 32);
      rdchk(HIRQ_OFF_EXTENDED, 32'h0);
      if (b) begin
        pulse(e_col);
      end else begin
        cts <= 1'h0;
        repeat (6) @(posedge hclk);
        cts <= 1'h1;
      end
      rdchk(HIRQ_OFF_EXTENDED, ex(HIRQ_E_XMR));
    end
    // Underrun without message end; none when the DMA count matches
    wr(HIRQ_OFF_CONFIG, 32'h0);
    wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_XTF));
    pulse(e_bys);
    shmt <= 1'h1;
    repeat (3) @(posedge hclk);
    rdchk(HIRQ_OFF_EXTENDED, ex(HIRQ_E_XDU));
    shmt <= 1'h0;
    wr(HIRQ_OFF_CONFIG, ex(HIRQ_C_DMA));
    wr(HIRQ_OFF_TXCOUNT, 32'h2);
    wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_TX_RESET_CMD));
    wr(HIRQ_OFF_COMMAND, ex(HIRQ_K_XTF));
    host.xfer(1'h0, HIRQ_OFF_EXTENDED, 32'h0, rd);
    pulse(e_bys, 2);
    shmt <= 1'h1;
    repeat (3) @(posedge hclk);
    rdchk(HIRQ_OFF_EXTENDED, 32'h0);
    shmt <= 1'h0;
    summarize;
  end
endmodule
